// file: bench/mtc_copy_top_tb.sv
`timescale 1ns/1ps
module mtc_copy_top_tb
	import mtc_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        copy_busy;
	logic        copy_done;
	logic        disp_valid;
	logic [4:0]  disp_idx;
	logic [15:0] disp_word;
	logic [15:0] exp_t2 [20];
	int          bad_count;
	int          n_checks;
	int          done_cnt;

	mtc_copy_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .copy_busy(copy_busy), .copy_done(copy_done),
		.disp_valid(disp_valid), .disp_idx(disp_idx), .disp_word(disp_word));

	mtc_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// Free-running clock.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Count completed copies from the done pulse.
	always @(posedge pclk) begin
		if (copy_done === 1'b1)
			done_cnt++;
	end

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function automatic logic [11:0] ta(input int t, input int w);
		return {1'b1, t[3:0], w[4:0], 2'b00};
	endfunction

	// A poll may land anywhere, so wait two periods plus the longest copy.
	task automatic settle;
		repeat (2 * POLL_CYC + 40) @(posedge pclk);
	endtask

	// Waits for a copy to start, then counts the cycles for which it stays busy.
	task automatic busy_len(input logic [31:0] exp);
		int n;
		n = 0;
		for (int i = 0; i < 2 * POLL_CYC && copy_busy !== 1'b1; i++)
			@(posedge pclk);
		while (copy_busy === 1'b1 && n < 40) begin
			n++;
			@(posedge pclk);
		end
		chk("copy busy cycles", n, exp);
	endtask

	task automatic check_t2(input int cnt);
		logic [31:0] q;
		logic        e;
		chk("copy count", done_cnt, cnt);
		for (int w = 0; w < 20; w++) begin
			host.xfer(1'b0, ta(2, w), 32'h0, q, e);
			chk("table 2 word", q, {16'h0, exp_t2[w]});
		end
	endtask

	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		for (int i = 0; i < 4; i++) begin
			host.xfer(1'b0, 12'(4 * i), 32'h0, q, e);
			chk("register reset", q, 32'h0);
		end
		host.xfer(1'b0, 12'h014, 32'h0, q, e);
		chk("unmapped error", {31'h0, e}, 32'h1);
		host.xfer(1'b0, ta(1, 20), 32'h0, q, e);
		chk("word range error", {31'h0, e}, 32'h1);
		$display("test reset done");
	endtask

	task automatic t_copies;
		logic [31:0] q;
		logic        e;
		for (int w = 0; w < 20; w++) begin
			host.wr(ta(1, w), 16'h1100 + 16'(w));
			host.wr(ta(3, w), 16'h3300 + 16'(w));
			host.wr(ta(2, w), 16'h0);
			exp_t2[w] = 16'h0;
		end
		host.set_copy(TYPE_NUMERAL, 16'h1, 16'h2);
		busy_len(32'(LEN_NUM) + 32'h2);
		settle();
		exp_t2[0] = 16'h1100;
		exp_t2[1] = 16'h1101;
		check_t2(1);
		host.wr(12'h008, 16'h2);
		host.wr(12'h004, 16'h1);
		host.wr(12'h000, TYPE_NUMERAL);
		settle();
		check_t2(1);
		host.wr(12'h000, 16'h0005);
		host.wr(12'h004, 16'h3);
		settle();
		check_t2(1);
		host.wr(ta(1, 0), 16'h1a1a);
		host.set_copy(TYPE_NUMERAL, 16'h1, 16'h2);
		busy_len(32'(LEN_NUM) + 32'h2);
		settle();
		exp_t2[0] = 16'h1a1a;
		check_t2(2);
		host.set_copy(TYPE_STRING, 16'h3, 16'h2);
		busy_len(32'(LEN_STR) + 32'h2);
		settle();
		for (int w = 0; w < 20; w++)
			exp_t2[w] = 16'h3300 + 16'(w);
		check_t2(3);
		// An out-of-range source must not copy, but must raise the sticky error.
		host.wr(12'h004, 16'h0010);
		settle();
		host.xfer(1'b0, 12'h010, 32'h0, q, e);
		chk("status count", {24'h0, q[15:8]}, 32'h3);
		chk("status error", {31'h0, q[1]}, 32'h1);
		host.wr(12'h010, 16'h0002);
		host.xfer(1'b0, 12'h010, 32'h0, q, e);
		chk("error cleared", {31'h0, q[1]}, 32'h0);
		$display("test copies done");
	endtask

	task automatic t_disp;
		int i;
		host.wr(12'h00c, 16'h2);
		// Words already read from the old table are still in flight; let them drain.
		repeat (4) @(posedge pclk);
		for (i = 0; i < 200 && disp_valid !== 1'b1; i++)
			@(posedge pclk);
		chk("display refresh", {31'h0, disp_valid}, 32'h1);
		chk("display word", {16'h0, disp_word}, {16'h0, exp_t2[disp_idx]});
		$display("test display done");
	endtask

	// Reset, then the scenarios in order.
	initial begin
		presetn = 1'b0;
		bad_count = 0;
		n_checks = 0;
		done_cnt = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_copies();
		t_disp();
		results();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		results();
	end
endmodule

// file: bench/mtc_host_model.sv
`timescale 1ns/1ps
// Host controller model: an APB master that owns the copy setting words.
module mtc_host_model
	import mtc_pkg::*;
(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// The bus is idle at time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// One transfer; idle address and data are inverted so no stale value lingers.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, a, {16'h0, d}, q, e);
	endtask

	// Parking the type on an invalid code keeps a mid-update poll harmless.
	task automatic set_copy(input logic [15:0] t, input logic [15:0] s, input logic [15:0] d);
		wr(12'h000, 16'h0005);
		wr(12'h008, d);
		wr(12'h004, s);
		wr(12'h000, t);
	endtask
endmodule

// file: hw/mtc_copy_top.sv
`timescale 1ns/1ps
module mtc_copy_top
	import mtc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             copy_busy,
	output logic             copy_done,
	output logic             disp_valid,
	output logic      [4:0]  disp_idx,
	output logic      [15:0] disp_word
);

	typedef struct packed {
		mtc_state_t  st;
		mtc_snap_t   set;
		mtc_snap_t   prev;
		logic [15:0] disp_tbl;
		logic [7:0]  poll_cnt;
		logic [4:0]  cnt;
		logic [4:0]  len;
		logic        cp_v;
		logic [4:0]  cp_w;
		logic [3:0]  csrc;
		logic [3:0]  cdst;
		logic        ard;
		logic        sc_v;
		logic [4:0]  sc_w;
		logic [7:0]  copies;
		logic        err;
		logic        done;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		mtc_disp_t   disp;
	} mtc_regs_t;

	localparam logic [7:0] POLL_LAST = 8'(POLL_CYC - 1);

	mtc_regs_t   s_r;
	mtc_regs_t   s_nxt;
	logic [15:0] rd_data;
	logic [8:0]  rd_idx;
	logic        mem_we;
	logic [8:0]  wr_idx;
	logic [15:0] wr_data;
	logic        poll_tick;
	logic        start_copy;
	logic        acc;
	logic [9:0]  reg_idx;
	logic [3:0]  win_tbl;
	logic [4:0]  win_wrd;
	logic        err_set;

	function automatic logic [8:0] midx(input logic [3:0] t, input logic [4:0] w);
		midx = 9'(9'(t) * TBL_STRIDE) + 9'(w);
	endfunction

	function automatic logic tbl_ok(input logic [15:0] t);
		tbl_ok = (t < 16'(NUM_TABLES));
	endfunction

	function automatic logic type_ok(input logic [15:0] t);
		type_ok = (t == TYPE_NUMERAL) || (t == TYPE_STRING);
	endfunction

	function automatic logic copies_ok(input logic [7:0] a, input logic [7:0] b);
		copies_ok = (a == 8'(b + 8'h01));
	endfunction

	mtc_table_mem u_mem (
		.pclk    (pclk),
		.rd_idx  (rd_idx),
		.rd_data (rd_data),
		.we      (mem_we),
		.wr_idx  (wr_idx),
		.wr_data (wr_data)
	);

	assign acc     = psel && penable && !s_r.pready;
	assign reg_idx = paddr[TBL_WIN_BIT:WRD_LSB];
	assign win_tbl = paddr[TBL_MSB:TBL_LSB];
	assign win_wrd = paddr[WRD_MSB:WRD_LSB];

	// Single next-state process; memory port priority is copy, then bus, then display.
	always_comb begin
		s_nxt      = s_r;
		rd_idx     = midx(s_r.disp_tbl[3:0], s_r.sc_w);
		mem_we     = 1'b0;
		wr_idx     = midx(s_r.cdst, s_r.cp_w);
		wr_data    = rd_data;
		start_copy = 1'b0;
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.done    = 1'b0;
		s_nxt.sc_v    = 1'b0;
		s_nxt.disp.valid = 1'b0;
		err_set    = 1'b0;

		// Poll timer; sampling is not interlocked with bus writes.
		poll_tick = (s_r.poll_cnt == POLL_LAST);
		s_nxt.poll_cnt = poll_tick ? 8'h00 : 8'(s_r.poll_cnt + 8'h01);
		if (poll_tick && (s_r.set != s_r.prev)) begin
			s_nxt.prev = s_r.set;
			if (type_ok(s_r.set.ctype)) begin
				if (tbl_ok(s_r.set.src) && tbl_ok(s_r.set.dst)) begin
					start_copy = (s_r.st == MTC_IDLE);
				end else begin
					s_nxt.err = 1'b1;
					err_set   = 1'b1;
				end
			end
		end

		unique case (s_r.st)
			MTC_IDLE: begin
				if (start_copy) begin
					// A pending table read is reissued after the copy, as its data is lost.
					s_nxt.ard  = 1'b0;
					s_nxt.st   = MTC_COPY;
					s_nxt.cnt  = 5'h00;
					s_nxt.cp_v = 1'b0;
					s_nxt.csrc = s_r.set.src[3:0];
					s_nxt.cdst = s_r.set.dst[3:0];
					s_nxt.len  = (s_r.set.ctype == TYPE_STRING) ? LEN_STR : LEN_NUM;
				end
			end
			MTC_COPY: begin
				// Write lags the read by one cycle, matching the memory latency.
				if (s_r.cp_v) begin
					mem_we = 1'b1;
				end
				if (s_r.cnt < s_r.len) begin
					rd_idx     = midx(s_r.csrc, s_r.cnt);
					s_nxt.cp_v = 1'b1;
					s_nxt.cp_w = s_r.cnt;
					s_nxt.cnt  = 5'(s_r.cnt + 5'h01);
				end else begin
					s_nxt.cp_v = 1'b0;
					if (!s_r.cp_v) begin
						s_nxt.st     = MTC_IDLE;
						s_nxt.done   = 1'b1;
						s_nxt.copies = 8'(s_r.copies + 8'h01);
					end
				end
			end
		endcase

		// Bus access: settings registers answer at once, table words wait for the copy.
		if (acc && !paddr[TBL_WIN_BIT]) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = 32'h0000_0000;
			unique case (reg_idx)
				IDX_COPY_TYPE: begin
					s_nxt.prdata = {16'h0000, s_r.set.ctype};
					if (pwrite) s_nxt.set.ctype = pwdata[15:0];
				end
				IDX_SRC: begin
					s_nxt.prdata = {16'h0000, s_r.set.src};
					if (pwrite) s_nxt.set.src = pwdata[15:0];
				end
				IDX_DST: begin
					s_nxt.prdata = {16'h0000, s_r.set.dst};
					if (pwrite) s_nxt.set.dst = pwdata[15:0];
				end
				IDX_DISP: begin
					s_nxt.prdata = {16'h0000, s_r.disp_tbl};
					if (pwrite) s_nxt.disp_tbl = pwdata[15:0];
				end
				IDX_STATUS: begin
					s_nxt.prdata[ST_BUSY_BIT] = (s_r.st == MTC_COPY);
					s_nxt.prdata[ST_ERR_BIT]  = s_r.err;
					s_nxt.prdata[ST_CNT_LSB +: 8] = s_r.copies;
					// Write one to clear; a new error in the same cycle still wins.
					if (pwrite && pwdata[ST_ERR_BIT] && !err_set) begin
						s_nxt.err = 1'b0;
					end
				end
				default: s_nxt.pslverr = 1'b1;
			endcase
		end else if (acc && (win_wrd >= TBL_WORDS)) begin
			s_nxt.pready  = 1'b1;
			s_nxt.pslverr = 1'b1;
			s_nxt.prdata  = 32'h0000_0000;
		end else if (acc && (s_r.st == MTC_IDLE) && !start_copy) begin
			if (pwrite) begin
				mem_we       = 1'b1;
				wr_idx       = midx(win_tbl, win_wrd);
				wr_data      = pwdata[15:0];
				s_nxt.pready = 1'b1;
			end else if (s_r.ard) begin
				s_nxt.ard    = 1'b0;
				s_nxt.pready = 1'b1;
				s_nxt.prdata = {16'h0000, rd_data};
			end else begin
				rd_idx    = midx(win_tbl, win_wrd);
				s_nxt.ard = 1'b1;
			end
		end else if ((s_r.st == MTC_IDLE) && !start_copy && tbl_ok(s_r.disp_tbl)) begin
			// Refresh only the displayed table; idle cycles are otherwise free.
			s_nxt.sc_v = 1'b1;
			s_nxt.sc_w = (s_r.sc_w == 5'(TBL_WORDS - 5'h01)) ? 5'h00 : 5'(s_r.sc_w + 5'h01);
		end

		if (s_r.sc_v) begin
			s_nxt.disp.valid = 1'b1;
			s_nxt.disp.idx   = s_r.sc_w == 5'h00 ? 5'(TBL_WORDS - 5'h01) : 5'(s_r.sc_w - 5'h01);
			s_nxt.disp.word  = rd_data;
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{st: MTC_IDLE, set: '{SET_RST, SET_RST, SET_RST},
			         prev: '{SET_RST, SET_RST, SET_RST}, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata     = s_r.prdata;
	assign pready     = s_r.pready;
	assign pslverr    = s_r.pslverr;
	assign copy_busy  = (s_r.st == MTC_COPY);
	assign copy_done  = s_r.done;
	assign disp_valid = s_r.disp.valid;
	assign disp_idx   = s_r.disp.idx;
	assign disp_word  = s_r.disp.word;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");

	property p_start_change;
		start_copy |-> (s_r.set != s_r.prev) && poll_tick;
	endproperty
	a_start_change: assert property (p_start_change) else $error("copy without change");

	property p_type_valid;
		start_copy |-> type_ok(s_r.set.ctype);
	endproperty
	a_type_valid: assert property (p_type_valid) else $error("copy with bad type");

	property p_min_busy;
		$rose(copy_busy) |-> copy_busy[*4];
	endproperty
	a_min_busy: assert property (p_min_busy) else $error("copy ended too soon");

	property p_max_busy;
		$rose(copy_busy) |-> ##[1:23] !copy_busy;
	endproperty
	a_max_busy: assert property (p_max_busy) else $error("copy overran");

	property p_done_count;
		$fell(copy_busy) |-> copy_done && (copies_ok(s_r.copies, $past(s_r.copies)));
	endproperty
	a_done_count: assert property (p_done_count) else $error("copy count wrong");

	property p_same_no_copy;
		poll_tick && (s_r.set == s_r.prev) && !copy_busy |=> !copy_busy;
	endproperty
	a_same_no_copy: assert property (p_same_no_copy) else $error("copy on same values");

	property p_disp_table;
		s_r.sc_v |-> tbl_ok(s_r.disp_tbl) && (s_r.st == MTC_IDLE);
	endproperty
	a_disp_table: assert property (p_disp_table) else $error("refresh of wrong table");

	property p_copy_write;
		mem_we && copy_busy |-> wr_idx == midx(s_r.cdst, $past(s_r.cnt));
	endproperty
	a_copy_write: assert property (p_copy_write) else $error("copy wrote wrong word");

endmodule

// file: hw/mtc_pkg.sv
package mtc_pkg;

	// Clock and polling period of the control word area.
	localparam int CLK_NS   = 50;
	localparam int POLL_NS  = 10000;
	localparam int POLL_CYC = (POLL_NS + CLK_NS - 1) / CLK_NS;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0] IDX_COPY_TYPE = 10'h000;
	localparam logic [9:0] IDX_SRC       = 10'h001;
	localparam logic [9:0] IDX_DST       = 10'h002;
	localparam logic [9:0] IDX_DISP      = 10'h003;
	localparam logic [9:0] IDX_STATUS    = 10'h004;

	// Table window: address bit 11 selects it, then table and word fields.
	localparam int TBL_WIN_BIT = 11;
	localparam int TBL_MSB     = 10;
	localparam int TBL_LSB     = 7;
	localparam int WRD_MSB     = 6;
	localparam int WRD_LSB     = 2;

	// Memory table geometry.
	localparam int         NUM_TABLES = 16;
	localparam int         MEM_WORDS  = 320;
	localparam logic [8:0] TBL_STRIDE = 9'h014;
	localparam logic [4:0] TBL_WORDS  = 5'h14;
	localparam logic [4:0] LEN_NUM    = 5'h02;
	localparam logic [4:0] LEN_STR    = 5'h14;

	// Copy type codes that start a copy.
	localparam logic [15:0] TYPE_NUMERAL = 16'h0000;
	localparam logic [15:0] TYPE_STRING  = 16'h0001;

	// Reset values of the setting words.
	localparam logic [15:0] SET_RST = 16'h0000;

	// Status register fields.
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ERR_BIT  = 1;
	localparam int ST_CNT_LSB  = 8;

	typedef enum logic [1:0] {
		MTC_IDLE = 2'b01,
		MTC_COPY = 2'b10
	} mtc_state_t;

	// One copy request as seen on a poll.
	typedef struct packed {
		logic [15:0] ctype;
		logic [15:0] src;
		logic [15:0] dst;
	} mtc_snap_t;

	// Display refresh output group.
	typedef struct packed {
		logic        valid;
		logic [4:0]  idx;
		logic [15:0] word;
	} mtc_disp_t;

endpackage

// file: hw/mtc_table_mem.sv
`timescale 1ns/1ps
module mtc_table_mem
	import mtc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic [8:0]  rd_idx,
	output logic      [15:0] rd_data,
	input  wire logic        we,
	input  wire logic [8:0]  wr_idx,
	input  wire logic [15:0] wr_data
);

	logic [15:0] mem [MEM_WORDS];

	// Read data is registered, so every reader sees it one cycle after the address.
	// No reset: table contents are loaded by software before use.
	always_ff @(posedge pclk) begin
		rd_data <= mem[rd_idx];
		if (we) begin
			mem[wr_idx] <= wr_data;
		end
	end

endmodule
